// ==== pkg/iop_defs.vh ====
`ifndef IOP_DEFS_VH
`define IOP_DEFS_VH

// register index within one port window
`define IOP_REG_DIN 4'h0
`define IOP_REG_DOUT 4'h1
`define IOP_REG_DIR 4'h2
`define IOP_REG_DRIVE 4'h3
`define IOP_REG_CTRL 4'h4
`define IOP_REG_OUTCELL 4'h5
`define IOP_REG_MASK 4'h6
`define IOP_REG_INCELL 4'h7
`define IOP_REG_ENOUT 4'h8

// port numbers in the upper address bits
`define IOP_PORT_A 2'h0
`define IOP_PORT_B 2'h1
`define IOP_PORT_C 2'h2
`define IOP_PORT_D 2'h3

// reset value of every configuration byte
`define IOP_RST_BYTE 8'h00

// live bits of each port
`define IOP_FULL_MASK 8'hff
`define IOP_PORTD_MASK 8'h06

// drive select field layout
`define IOP_AB_OD_MASK 8'hf0
`define IOP_AB_SLEW_MASK 8'h0f
`define IOP_C_OD_MASK 8'hff
`define IOP_D_SLEW_MASK 8'h06

// port D pin positions in the flat pin vector
`define IOP_CLKPIN_BIT 25
`define IOP_SELPIN_BIT 26

`endif

// ==== rtl/iop_pin_sync.v ====
`timescale 1ns/10ps
// two-stage synchroniser for pin levels
module iop_pin_sync #(
	parameter W = 26
) (
	input wire clock,
	input wire rst_n,
	input wire [W-1:0] din,
	output reg [W-1:0] dout
);

	reg [W-1:0] stage1Q;

	// first stage feeds only the second one
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1Q <= {W{1'b0}};
			dout <= {W{1'b0}};
		end
		else
		begin
			stage1Q <= din;
			dout <= stage1Q;
		end
	end

endmodule // iop_pin_sync

// ==== rtl/iop_port_data_path.v ====
// Operation
// R1 - input register reads live pin levels
// R2 - output data drives pin when enabled
// R3 - output register reads back written value
// R4 - cell location reads output cell flops
// R5 - cell write loads unmasked cell flops
// R6 - mask bit blocks loads, resets clear
// R7 - input cells capture pins, feed logic
// R8 - enable status reports drivers per pin
// R9 - A/B: low slew, high open drain
// R10 - port C drive bits open drain only
// R11 - port D uses bits two, one
// R12 - only ports A/B have mode control
// R13 - port D pins go straight to logic
// R14 - cell banks route A/B and B/C
// R15 - chip select high disables memories
// R16 - clock pin clocks cells, power counter
// R17 - port D outputs external selects
// R18 - A/B output latched low address
// R19 - direction one output, resets input
// R20 - mode zero cpu io, one address
// R21 - enable is direction OR logic term
// R22 - address bits map pin for pin
// R23 - status shows same enable as driver
`timescale 1ns/10ps
`include "iop_defs.vh"
module iop_port_data_path (
	input wire clock,
	input wire rst_n,
	input wire [5:0] cpuAddr,
	input wire cpuWr,
	input wire cpuRd,
	input wire [7:0] cpuWrData,
	output reg [7:0] cpuRdData,
	output reg cpuRdValid,
	input wire addrStrobe,
	input wire [7:0] cpuAddrLow,
	input wire [7:0] pinInA,
	input wire [7:0] pinInB,
	input wire [7:0] pinInC,
	input wire [2:1] pinInD,
	output wire [7:0] pinOutA,
	output wire [7:0] pinOutB,
	output wire [7:0] pinOutC,
	output wire [2:1] pinOutD,
	output wire [7:0] pinOeNA,
	output wire [7:0] pinOeNB,
	output wire [7:0] pinOeNC,
	output wire [2:1] pinOeND,
	output wire [7:0] fastSlewA,
	output wire [7:0] fastSlewB,
	output wire [2:1] fastSlewD,
	input wire [7:0] plaOeA,
	input wire [7:0] plaOeB,
	input wire [7:0] plaOeC,
	input wire [2:1] plaOeD,
	input wire [7:0] plaPinSelA,
	input wire [7:0] plaPinSelB,
	input wire [7:0] plaPinSelC,
	input wire [2:1] plaPinSelD,
	input wire [15:0] cellNext,
	input wire [7:0] abToB,
	input wire [7:0] bcToC,
	input wire [1:0] extSelect,
	input wire [2:0] inCellGate,
	input wire clkInSel,
	input wire chipSelInSel,
	output reg [23:0] plaInCells,
	output wire [2:1] plaDirectD,
	output reg [15:0] cellOut,
	output reg powerDownTick,
	output reg mainFlashOff,
	output reg secFlashOff,
	output reg sramOff,
	output reg ioBlockOff
);

	////////////////////////////////////////////////////////////
	// helpers

	// bits of a port that exist
	function [7:0] portMask;
		input [1:0] p;
		begin
			portMask = (p == `IOP_PORT_D) ? `IOP_PORTD_MASK : `IOP_FULL_MASK;
		end
	endfunction

	// drive bits that pick open drain
	function [7:0] odMask;
		input [1:0] p;
		begin
			case (p)
				`IOP_PORT_A: odMask = `IOP_AB_OD_MASK; // R9
				`IOP_PORT_B: odMask = `IOP_AB_OD_MASK; // R9
				`IOP_PORT_C: odMask = `IOP_C_OD_MASK; // R10
				default: odMask = 8'h00;
			endcase
		end
	endfunction

	// drive bits that pick fast slew
	function [7:0] slewMask;
		input [1:0] p;
		begin
			case (p)
				`IOP_PORT_A: slewMask = `IOP_AB_SLEW_MASK; // R9
				`IOP_PORT_B: slewMask = `IOP_AB_SLEW_MASK; // R9
				`IOP_PORT_D: slewMask = `IOP_D_SLEW_MASK; // R11
				default: slewMask = 8'h00;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////
	// pin synchronisers

	wire [26:0] pinSync;
	wire [31:0] pinLvl;

	// pins are asynchronous to the core clock
	iop_pin_sync #(
		.W(27)
	) uPinSync (
		.clock(clock),
		.rst_n(rst_n),
		.din({pinInD, 1'b0, pinInC, pinInB, pinInA}),
		.dout(pinSync)
	);

	// byte per port, port D at bits 2:1
	assign pinLvl = {5'h00, pinSync[26:24], pinSync[23:0]};
	assign plaDirectD = pinSync[`IOP_SELPIN_BIT:`IOP_CLKPIN_BIT]; // R13

	////////////////////////////////////////////////////////////
	// cpu access decode

	wire [1:0] accPort;
	wire [3:0] accReg;
	wire [4:0] accBase;
	wire wrHit;
	wire bankSel;

	assign accPort = cpuAddr[5:4];
	assign accReg = cpuAddr[3:0];
	assign accBase = {accPort, 3'b000};
	// a deselected register block ignores the cpu
	assign wrHit = cpuWr & ~ioBlockOff; // R15
	// port A sees the first bank, B and C the second
	assign bankSel = (accPort != `IOP_PORT_A);

	////////////////////////////////////////////////////////////
	// configuration and data registers

	reg [31:0] dataOutQ;
	reg [31:0] dirQ;
	reg [31:0] driveQ;
	reg [15:0] ctrlQ;
	reg [15:0] maskQ;

	// cpu writes; unused bits never stick
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dataOutQ <= {4{`IOP_RST_BYTE}};
			dirQ <= {4{`IOP_RST_BYTE}}; // R19
			driveQ <= {4{`IOP_RST_BYTE}};
			ctrlQ <= {2{`IOP_RST_BYTE}}; // R20
			maskQ <= {2{`IOP_RST_BYTE}}; // R6
		end
		else if (wrHit)
		begin
			case (accReg)
				`IOP_REG_DOUT:
					dataOutQ[accBase +: 8] <= cpuWrData & portMask(accPort); // R11
				`IOP_REG_DIR:
					dirQ[accBase +: 8] <= cpuWrData & portMask(accPort); // R19
				`IOP_REG_DRIVE:
					driveQ[accBase +: 8] <= cpuWrData & (odMask(accPort) | slewMask(accPort));
				`IOP_REG_CTRL:
					if (accPort == `IOP_PORT_A || accPort == `IOP_PORT_B)
						ctrlQ[accBase[3:0] +: 8] <= cpuWrData; // R12
				`IOP_REG_MASK:
					if (accPort != `IOP_PORT_D)
						maskQ[{bankSel, 3'b000} +: 8] <= cpuWrData; // R6
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// logic clock input and cell timing

	reg clkPinLastQ;
	wire cellTick;

	// edge memory of the synchronised clock pin
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			clkPinLastQ <= 1'b0;
		else
			clkPinLastQ <= pinSync[`IOP_CLKPIN_BIT];
	end

	// rising pin edge clocks cells, else every cycle
	assign cellTick = clkInSel ? (pinSync[`IOP_CLKPIN_BIT] & ~clkPinLastQ) : 1'b1; // R16

	// tick for the power-down counter
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			powerDownTick <= 1'b0;
		else
			powerDownTick <= clkInSel & pinSync[`IOP_CLKPIN_BIT] & ~clkPinLastQ; // R16
	end

	////////////////////////////////////////////////////////////
	// output cells

	integer c;

	// cpu load beats the logic update in the same cycle
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cellOut <= 16'h0000;
		else
		begin
			for (c = 0; c < 16; c = c + 1)
			begin
				if (wrHit && accReg == `IOP_REG_OUTCELL && accPort != `IOP_PORT_D
					&& bankSel == c[3] && !maskQ[c])
					cellOut[c] <= cpuWrData[c % 8]; // R5
				else if (cellTick)
					cellOut[c] <= cellNext[c]; // R16
			end
		end
	end

	////////////////////////////////////////////////////////////
	// input cells and address latch

	integer g;
	reg [7:0] addrLatchQ;

	// a gated port tracks its pins, otherwise holds
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			plaInCells <= 24'h000000;
		else
		begin
			for (g = 0; g < 3; g = g + 1)
			begin
				if (inCellGate[g])
					plaInCells[g*8 +: 8] <= pinLvl[g*8 +: 8]; // R7
			end
		end
	end

	// low address byte captured on the strobe
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			addrLatchQ <= 8'h00;
		else if (addrStrobe)
			addrLatchQ <= cpuAddrLow; // R18
	end

	////////////////////////////////////////////////////////////
	// pin output selection

	wire [31:0] plaOeAll;
	wire [31:0] plaSelAll;
	reg [31:0] outD;
	reg [31:0] enD;
	reg [31:0] oeND;
	reg [31:0] slewD;
	reg [31:0] cellVal;
	reg [1:0] bp;
	reg [2:0] bi;
	reg odBit;
	reg [7:0] liveV;
	reg [7:0] odV;
	reg [7:0] slewV;
	integer b;

	assign plaOeAll = {5'h00, plaOeD, 1'b0, plaOeC, plaOeB, plaOeA};
	assign plaSelAll = {5'h00, plaPinSelD, 1'b0, plaPinSelC, plaPinSelB, plaPinSelA};

	// per pin source, enable and drive style
	always @*
	begin
		outD = 32'h00000000;
		enD = 32'h00000000;
		oeND = 32'hffffffff;
		slewD = 32'h00000000;
		cellVal = 32'h00000000;
		bp = 2'h0;
		bi = 3'h0;
		odBit = 1'b0;
		liveV = 8'h00;
		odV = 8'h00;
		slewV = 8'h00;
		for (b = 0; b < 32; b = b + 1)
		begin
			bp = b[4:3];
			bi = b[2:0];
			// routing of the two cell banks
			case (bp)
				`IOP_PORT_A: cellVal[b] = ~abToB[bi] & cellOut[bi]; // R14
				`IOP_PORT_B: cellVal[b] = abToB[bi] ? cellOut[bi]
					: (~bcToC[bi] & cellOut[8 + bi]); // R14
				`IOP_PORT_C: cellVal[b] = bcToC[bi] & cellOut[8 + bi]; // R14
				default: cellVal[b] = (bi == 3'h1) ? extSelect[0]
					: (bi == 3'h2) ? extSelect[1] : 1'b0; // R17
			endcase
			if (bp[1] == 1'b0 && ctrlQ[{bp[0], bi}])
				outD[b] = addrLatchQ[bi]; // R22
			else if (plaSelAll[b])
				outD[b] = cellVal[b];
			else
				outD[b] = dataOutQ[b]; // R2
			// function results go through temporaries before a bit is picked
			liveV = portMask(bp);
			odV = odMask(bp);
			slewV = slewMask(bp);
			enD[b] = (dirQ[b] | plaOeAll[b]) & liveV[bi]; // R21
			odBit = driveQ[b] & odV[bi];
			slewD[b] = driveQ[b] & slewV[bi];
			// open drain only ever pulls low
			oeND[b] = ~(enD[b] & ~(odBit & outD[b])); // R2
		end
		// dedicated input functions keep their pins quiet; index is the flat pin bit
		if (clkInSel)
		begin
			enD[`IOP_CLKPIN_BIT] = 1'b0;
			oeND[`IOP_CLKPIN_BIT] = 1'b1;
		end
		if (chipSelInSel)
		begin
			enD[`IOP_SELPIN_BIT] = 1'b0;
			oeND[`IOP_SELPIN_BIT] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////
	// registered pin drivers

	reg [31:0] pinOutQ;
	reg [31:0] pinOeNQ;
	reg [31:0] drvEnQ;
	reg [31:0] slewQ;

	// one flop stage between decode and the pads
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pinOutQ <= 32'h00000000;
			pinOeNQ <= 32'hffffffff; // R19
			drvEnQ <= 32'h00000000;
			slewQ <= 32'h00000000;
		end
		else
		begin
			pinOutQ <= outD;
			pinOeNQ <= oeND;
			drvEnQ <= enD; // R23
			slewQ <= slewD;
		end
	end

	assign pinOutA = pinOutQ[7:0];
	assign pinOutB = pinOutQ[15:8];
	assign pinOutC = pinOutQ[23:16];
	assign pinOutD = pinOutQ[26:25];
	assign pinOeNA = pinOeNQ[7:0];
	assign pinOeNB = pinOeNQ[15:8];
	assign pinOeNC = pinOeNQ[23:16];
	assign pinOeND = pinOeNQ[26:25];
	assign fastSlewA = slewQ[7:0];
	assign fastSlewB = slewQ[15:8];
	assign fastSlewD = slewQ[26:25];

	////////////////////////////////////////////////////////////
	// chip select input

	// high level on the select pin parks the memories
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mainFlashOff <= 1'b0;
			secFlashOff <= 1'b0;
			sramOff <= 1'b0;
			ioBlockOff <= 1'b0;
		end
		else
		begin
			mainFlashOff <= chipSelInSel & pinSync[`IOP_SELPIN_BIT]; // R15
			secFlashOff <= chipSelInSel & pinSync[`IOP_SELPIN_BIT]; // R15
			sramOff <= chipSelInSel & pinSync[`IOP_SELPIN_BIT]; // R15
			ioBlockOff <= chipSelInSel & pinSync[`IOP_SELPIN_BIT]; // R15
		end
	end

	////////////////////////////////////////////////////////////
	// cpu read path

	reg [7:0] rdD;

	// unmapped locations and missing ports read zero
	always @*
	begin
		rdD = 8'h00;
		case (accReg)
			`IOP_REG_DIN:
				rdD = pinLvl[accBase +: 8] & portMask(accPort); // R1
			`IOP_REG_DOUT:
				rdD = dataOutQ[accBase +: 8]; // R3
			`IOP_REG_DIR:
				rdD = dirQ[accBase +: 8];
			`IOP_REG_DRIVE:
				rdD = driveQ[accBase +: 8];
			`IOP_REG_CTRL:
				if (accPort[1] == 1'b0)
					rdD = ctrlQ[accBase[3:0] +: 8]; // R12
			`IOP_REG_OUTCELL:
				if (accPort != `IOP_PORT_D)
					rdD = cellOut[{bankSel, 3'b000} +: 8]; // R4
			`IOP_REG_MASK:
				if (accPort != `IOP_PORT_D)
					rdD = maskQ[{bankSel, 3'b000} +: 8]; // R6
			`IOP_REG_INCELL:
				if (accPort != `IOP_PORT_D)
					rdD = plaInCells[accBase +: 8]; // R7
			`IOP_REG_ENOUT:
				if (accPort != `IOP_PORT_D)
					rdD = drvEnQ[accBase +: 8]; // R8
			default:
				rdD = 8'h00;
		endcase
		// the deselected block answers with zero
		if (ioBlockOff)
			rdD = 8'h00; // R15
	end

	// read data one cycle after the strobe
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpuRdData <= 8'h00;
			cpuRdValid <= 1'b0;
		end
		else
		begin
			cpuRdValid <= cpuRd;
			cpuRdData <= cpuRd ? rdD : 8'h00;
		end
	end

endmodule // iop_port_data_path

// ==== test/iop_pad_model.sv ====
`timescale 1ns/10ps
// pad ring of ports A..D, flat as {D[2:1], C, B, A}
module iop_pad_model (
	input wire [25:0] padOut,
	input wire [25:0] padOeN,
	input wire [25:0] outsideLevel,
	output wire [25:0] padLevel
);
	// a released pad shows the outside level; open drain highs lean on that same external pull-up
	assign padLevel = (padOeN & outsideLevel) | (~padOeN & padOut);
endmodule // iop_pad_model

// ==== test/iop_port_data_path_monitor.sv ====
`timescale 1ns/10ps
module iop_dp_monitor (
	input wire clock,
	input wire rst_n,
	input wire [5:0] cpuAddr,
	input wire cpuRd,
	input wire [7:0] cpuRdData,
	input wire cpuRdValid,
	input wire [7:0] plaOeA,
	input wire [7:0] pinOeNA,
	input wire [7:0] fastSlewA,
	input wire [7:0] fastSlewB,
	input wire [2:1] pinInD,
	input wire [2:1] pinOutD,
	input wire [2:1] plaPinSelD,
	input wire [1:0] extSelect,
	input wire clkInSel,
	input wire chipSelInSel,
	input wire powerDownTick,
	input wire mainFlashOff,
	input wire secFlashOff,
	input wire sramOff,
	input wire ioBlockOff
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	// the select pin needs two sync stages plus the flag register
	sequence selectHeld;
		(chipSelInSel && pinInD[2]) [*4];
	endsequence
	sequence readPortD;
		cpuRd && cpuAddr[5:4] == 2'h3;
	endsequence
	////////////////////////////////////////////////////////////////
	a_read_answered: assert property (cpuRd |=> cpuRdValid) else $error("read not answered");
	a_oe_term_drives: assert property ((plaOeA[3:0] != 4'h0) |=> (pinOeNA[3:0] & $past(plaOeA[3:0])) == 4'h0)
		else $error("logic enable term did not drive pin");
	a_select_disables: assert property (selectHeld |-> ioBlockOff && sramOff && mainFlashOff && secFlashOff)
		else $error("select input did not disable blocks");
	a_select_idle: assert property ((!chipSelInSel) [*4] |-> !ioBlockOff) else $error("block off without select");
	a_refused_zero: assert property (cpuRd && ioBlockOff |=> cpuRdValid && cpuRdData == 8'h00)
		else $error("blocked read returned data");
	a_tick_needs_clk: assert property ((!clkInSel) [*4] |-> !powerDownTick) else $error("tick without clock input");
	a_tick_single: assert property (powerDownTick |=> !powerDownTick) else $error("tick longer than a cycle");
	a_ext_select: assert property (plaPinSelD == 2'h3 |=> pinOutD == $past(extSelect))
		else $error("external select not on port D");
	a_portd_nomode: assert property (readPortD ##0 cpuAddr[3:0] == 4'h4 |=> cpuRdData == 8'h00)
		else $error("port D mode register present");
	a_portd_bits: assert property (readPortD |=> (cpuRdData & 8'hf9) == 8'h00) else $error("port D dead bit set");
	a_slew_low: assert property (fastSlewA[7:4] == 4'h0 && fastSlewB[7:4] == 4'h0)
		else $error("slew on open drain pins");
endmodule // iop_dp_monitor

bind iop_port_data_path iop_dp_monitor mon_u (.clock(clock), .rst_n(rst_n), .cpuAddr(cpuAddr), .cpuRd(cpuRd),
	.cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid), .plaOeA(plaOeA), .pinOeNA(pinOeNA), .fastSlewA(fastSlewA),
	.fastSlewB(fastSlewB), .pinInD(pinInD), .pinOutD(pinOutD), .plaPinSelD(plaPinSelD), .extSelect(extSelect),
	.clkInSel(clkInSel), .chipSelInSel(chipSelInSel), .powerDownTick(powerDownTick), .mainFlashOff(mainFlashOff),
	.secFlashOff(secFlashOff), .sramOff(sramOff), .ioBlockOff(ioBlockOff));

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	reg clock, rst_n, cpuWr, cpuRd, addrStrobe, clkInSel, chipSelInSel;
	reg [5:0] cpuAddr;
	reg [7:0] cpuWrData, cpuAddrLow, plaOeA, plaOeB, plaOeC, plaPinSelA, plaPinSelB, plaPinSelC, abToB, bcToC;
	reg [2:1] plaOeD, plaPinSelD;
	reg [15:0] cellNext;
	reg [1:0] extSelect;
	reg [2:0] inCellGate;
	reg [25:0] ext;
	wire [7:0] cpuRdData, pinInA, pinInB, pinInC, pinOutA, pinOutB, pinOutC, pinOeNA, pinOeNB, pinOeNC;
	wire [7:0] fastSlewA, fastSlewB;
	wire [2:1] pinInD, pinOutD, pinOeND, fastSlewD, plaDirectD;
	wire [23:0] plaInCells;
	wire [15:0] cellOut;
	wire cpuRdValid, powerDownTick, mainFlashOff, secFlashOff, sramOff, ioBlockOff;
	integer badCount, totalChecks;
	////////////////////////////////////////////////////////////////
	iop_port_data_path dut_u (.clock(clock), .rst_n(rst_n), .cpuAddr(cpuAddr), .cpuWr(cpuWr), .cpuRd(cpuRd),
		.cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid), .addrStrobe(addrStrobe),
		.cpuAddrLow(cpuAddrLow), .pinInA(pinInA), .pinInB(pinInB), .pinInC(pinInC), .pinInD(pinInD),
		.pinOutA(pinOutA), .pinOutB(pinOutB), .pinOutC(pinOutC), .pinOutD(pinOutD), .pinOeNA(pinOeNA),
		.pinOeNB(pinOeNB), .pinOeNC(pinOeNC), .pinOeND(pinOeND), .fastSlewA(fastSlewA), .fastSlewB(fastSlewB),
		.fastSlewD(fastSlewD), .plaOeA(plaOeA), .plaOeB(plaOeB), .plaOeC(plaOeC), .plaOeD(plaOeD),
		.plaPinSelA(plaPinSelA), .plaPinSelB(plaPinSelB), .plaPinSelC(plaPinSelC), .plaPinSelD(plaPinSelD),
		.cellNext(cellNext), .abToB(abToB), .bcToC(bcToC), .extSelect(extSelect), .inCellGate(inCellGate),
		.clkInSel(clkInSel), .chipSelInSel(chipSelInSel), .plaInCells(plaInCells), .plaDirectD(plaDirectD),
		.cellOut(cellOut), .powerDownTick(powerDownTick), .mainFlashOff(mainFlashOff), .secFlashOff(secFlashOff),
		.sramOff(sramOff), .ioBlockOff(ioBlockOff));
	iop_pad_model pads_u (.padOut({pinOutD, pinOutC, pinOutB, pinOutA}), .padOeN({pinOeND, pinOeNC, pinOeNB, pinOeNA}),
		.outsideLevel(ext), .padLevel({pinInD, pinInC, pinInB, pinInA}));
	////////////////////////////////////////////////////////////////
	task cmp(input string what, input [15:0] exp, input [15:0] got);
		totalChecks = totalChecks + 1;
		if (got !== exp)
		begin
			badCount = badCount + 1;
			$display("mismatch %0s expected %h seen %h", what, exp, got);
		end
	endtask
	// strobes rise and fall on falling edges, so each one spans exactly one rising edge
	task wr(input [5:0] a, input [7:0] d);
		@(negedge clock);
		cpuAddr = a;
		cpuWrData = d;
		cpuWr = 1'h1;
		@(negedge clock);
		cpuWr = 1'h0;
	endtask
	task rd(input [5:0] a, input [7:0] e, input string what);
		@(negedge clock);
		cpuAddr = a;
		cpuRd = 1'h1;
		@(negedge clock);
		cpuRd = 1'h0;
		cmp(what, {8'h01, e}, {7'h00, cpuRdValid, cpuRdData});
	endtask
	task finishTest;
		if (badCount == 0 && totalChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset;
		rd(6'h02, 8'h00, "dirA");
		rd(6'h04, 8'h00, "modeA");
		rd(6'h06, 8'h00, "maskA");
		cmp("oeNA", 16'h00ff, {8'h00, pinOeNA});
	endtask
	// direction and logic enable share the drivers; undriven pins read the outside level
	task t_output;
		wr(6'h01, 8'ha5);
		wr(6'h02, 8'h03);
		plaOeA = 8'h3c;
		inCellGate = 3'h1;
		repeat (6) @(negedge clock);
		cmp("oeNA", 16'h00c0, {8'h00, pinOeNA});
		cmp("outA", 16'h00a5, {8'h00, pinOutA});
		rd(6'h00, 8'h25, "dinA");
		rd(6'h08, 8'h3f, "enA");
		rd(6'h01, 8'ha5, "doutA");
		rd(6'h07, 8'h25, "inCellA");
		cmp("inCellBus", 16'h0025, {8'h00, plaInCells[7:0]});
		cmp("directD", 16'h0002, {14'h0000, plaDirectD});
		plaOeA = 8'h00;
	endtask
	// cells hold between clock-pin edges, so a masked load is visible
	task t_cells;
		integer seen;
		seen = 0;
		clkInSel = 1'h1;
		repeat (4) @(negedge clock);
		cellNext = 16'h5ac3;
		wr(6'h06, 8'hf0);
		wr(6'h05, 8'h5a);
		cmp("cells", 16'h000a, cellOut);
		rd(6'h05, 8'h0a, "outCellA");
		rd(6'h06, 8'hf0, "maskA");
		// the clock pin function must leave port A drivers alone
		cmp("oeNA", 16'h00fc, {8'h00, pinOeNA});
		ext[24] = 1'h1;
		repeat (6)
		begin
			@(negedge clock);
			if (powerDownTick === 1'h1)
				seen = seen + 1;
		end
		cmp("ticks", 16'h0001, seen[15:0]);
		cmp("cells", 16'h5ac3, cellOut);
		clkInSel = 1'h0;
	endtask
	task t_route;
		{plaPinSelA, plaPinSelB, plaPinSelC} = 24'hffffff;
		abToB = 8'h0f;
		bcToC = 8'hf0;
		repeat (3) @(negedge clock);
		cmp("routeA", 16'h00c0, {8'h00, pinOutA});
		cmp("routeB", 16'h0003, {8'h00, pinOutB});
		cmp("routeC", 16'h0050, {8'h00, pinOutC});
		{plaPinSelA, plaPinSelB, plaPinSelC} = 24'h000000;
	endtask
	task t_addr;
		wr(6'h14, 8'hff);
		cpuAddrLow = 8'h96;
		addrStrobe = 1'h1;
		@(negedge clock);
		addrStrobe = 1'h0;
		cpuAddrLow = 8'h00;
		repeat (2) @(negedge clock);
		cmp("addrB", 16'h0096, {8'h00, pinOutB});
		rd(6'h14, 8'hff, "modeB");
	endtask
	task t_drive;
		wr(6'h03, 8'hff);
		wr(6'h23, 8'hff);
		wr(6'h33, 8'hff);
		wr(6'h32, 8'h06);
		wr(6'h21, 8'h0f);
		wr(6'h22, 8'hff);
		plaPinSelD = 2'h3;
		extSelect = 2'h2;
		repeat (3) @(negedge clock);
		cmp("slewA", 16'h000f, {8'h00, fastSlewA});
		cmp("slewD", 16'h0006, {13'h0000, fastSlewD, 1'h0});
		rd(6'h33, 8'h06, "driveD");
		rd(6'h23, 8'hff, "driveC");
		rd(6'h34, 8'h00, "modeD");
		cmp("ecs", 16'h0002, {14'h0000, pinOutD});
		cmp("oeND", 16'h0000, {14'h0000, pinOeND});
		// open drain port C releases its ones and pulls its zeros
		cmp("oeNC", 16'h000f, {8'h00, pinOeNC});
	endtask
	// while deselected a write must leave the port untouched
	task t_select;
		chipSelInSel = 1'h1;
		ext[25] = 1'h1;
		repeat (6) @(negedge clock);
		cmp("off", 16'h000f, {12'h000, mainFlashOff, secFlashOff, sramOff, ioBlockOff});
		cmp("oeND", 16'h0002, {14'h0000, pinOeND});
		rd(6'h01, 8'h00, "blocked");
		wr(6'h01, 8'h11);
		chipSelInSel = 1'h0;
		ext[25] = 1'h0;
		repeat (6) @(negedge clock);
		rd(6'h01, 8'ha5, "kept");
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end
	// whole run is under a hundred cycles; this limit only catches a hang
	initial
	begin
		#50000;
		badCount = badCount + 1;
		finishTest;
	end
	initial
	begin
		{cpuWr, cpuRd, addrStrobe, clkInSel, chipSelInSel} = 5'h00;
		{cpuAddr, cpuWrData, cpuAddrLow, cellNext, extSelect, inCellGate} = 43'h0;
		{plaOeA, plaOeB, plaOeC, plaOeD, plaPinSelA, plaPinSelB, plaPinSelC, plaPinSelD} = 52'h0;
		{abToB, bcToC} = 16'h0000;
		ext = {2'h2, 16'h0000, 8'h3c};
		badCount = 0;
		totalChecks = 0;
		rst_n = 1'h0;
		repeat (3) @(negedge clock);
		rst_n = 1'h1;
		t_reset;
		t_output;
		t_cells;
		t_route;
		t_addr;
		t_drive;
		t_select;
		finishTest;
	end
endmodule // testbench
